//--- verification/dku_dbg_model.sv
/* debugger model: drives the link front end strobes, keys and sync char.
   assumes: link clock stands low between frames, 160 ns period. */
`timescale 1ns/10ps
`default_nettype none
module dku_dbg_model (
    output logic link_clk_out,
    output logic link_rxd_out,
    output logic sync_active_out,
    output logic cs_wr_out,
    output logic cs_rd_out,
    output logic [3:0] cs_addr_out,
    output logic [7:0] cs_wdata_out,
    output logic key_valid_out,
    output logic key_first_out,
    output logic [7:0] key_byte_out,
    output logic bus_wr_out,
    output logic bus_rd_out,
    output logic [15:0] bus_addr_out,
    output logic [7:0] bus_wdata_out,
    input wire logic [7:0] cs_rdata_in
);
initial
begin
    {link_clk_out, sync_active_out, cs_wr_out, cs_rd_out} = 4'h0;
    {key_valid_out, key_first_out, bus_wr_out, bus_rd_out} = 4'h0;
    link_rxd_out = 1'b1;
    {cs_addr_out, cs_wdata_out, key_byte_out} = 20'h00000;
    {bus_addr_out, bus_wdata_out} = 24'h000000;
end
task automatic tick;
    begin
        #80 link_clk_out = 1'b1;
        #80 link_clk_out = 1'b0;
    end
endtask
// released lines flip so stale values never look valid
task automatic drop;
    begin
        {cs_wr_out, cs_rd_out, key_valid_out, key_first_out, bus_wr_out, bus_rd_out} = 6'h00;
        cs_addr_out = ~cs_addr_out;
        cs_wdata_out = ~cs_wdata_out;
        key_byte_out = ~key_byte_out;
        bus_addr_out = ~bus_addr_out;
        bus_wdata_out = ~bus_wdata_out;
    end
endtask
task automatic cs_op(input logic wr, input logic [3:0] a, input logic [7:0] d,
    output logic [7:0] q);
    begin
        #3 cs_wr_out = wr;
        cs_rd_out = !wr;
        cs_addr_out = a;
        cs_wdata_out = d;
        tick;
        drop;
        #40 q = cs_rdata_in;
    end
endtask
task automatic send_key(input logic [63:0] k);
    begin
        #3;
        for (int i = 0; i < 8; i++)
        begin
            key_valid_out = 1'b1;
            key_first_out = (i == 0);
            key_byte_out = k[8*i +: 8];
            tick;
        end
        drop;
    end
endtask
task automatic bus_op(input logic wr, input logic [15:0] a, input logic [7:0] d);
    begin
        #3 bus_wr_out = wr;
        bus_rd_out = !wr;
        bus_addr_out = a;
        bus_wdata_out = d;
        tick;
        drop;
    end
endtask
// start bit, 0x55 lsb first, stop bit: five rising edges
task automatic sync_char;
    begin
        #3 sync_active_out = 1'b1;
        for (int i = 0; i < 10; i++)
        begin
            link_rxd_out = i[0];
            #160;
        end
        #160 sync_active_out = 1'b0;
    end
endtask
endmodule // dku_dbg_model
`default_nettype wire

//--- verification/dku_props_properties.sv
/* port assertions and covers for dku_access.
   assumes: one clock domain, bound to the design below. */
`timescale 1ns/10ps
`default_nettype none
module dku_props (
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire logic lock_bits_in,
    input wire logic cpu_clk_off_in,
    input wire logic [1:0] bod_fuse_level_in,
    input wire logic sync_event_out,
    input wire logic keep_clock_out,
    input wire logic erase_req_out,
    input wire logic bod_force_out,
    input wire logic [1:0] bod_level_out,
    input wire logic nvm_prog_en_out,
    input wire logic row_prog_en_out,
    input wire logic sys_rd_out,
    input wire logic row_wr_out,
    input wire logic [4:0] row_addr_out,
    input wire logic [1:0] link_clk_sel_out
);
default clocking cb @(posedge sys_clk_in);
endclocking
default disable iff (!nrst_in);
a_prog_needs_unlock: assert property (
    nvm_prog_en_out |-> !lock_bits_in) else $error("prog on locked part");
a_row_needs_lock: assert property (
    row_prog_en_out |-> lock_bits_in) else $error("row prog on open part");
a_erase_forces_bod: assert property (
    erase_req_out |=> bod_force_out) else $error("bod not forced");
a_bod_fuse_level: assert property (
    bod_force_out |-> bod_level_out == $past(bod_fuse_level_in)) else $error("bod level");
a_no_read_locked: assert property (
    sys_rd_out |-> !$past(lock_bits_in)) else $error("bus read while locked");
a_sleep_blocks_bus: assert property (
    sys_rd_out |-> !($past(cpu_clk_off_in) && !$past(keep_clock_out)))
    else $error("bus read with clock stopped");
a_row_first_addr: assert property (
    $rose(row_wr_out) |-> row_addr_out == 5'h00) else $error("copy start address");
a_row_addr_step: assert property (
    row_wr_out && row_addr_out != 5'h1f
    |=> row_wr_out && row_addr_out == $past(row_addr_out) + 5'h01)
    else $error("copy address step");
a_row_copy_end: assert property (
    row_wr_out && row_addr_out == 5'h1f |=> !row_wr_out ##[0:1] !row_prog_en_out)
    else $error("copy end");
a_event_single: assert property (
    sync_event_out |=> !sync_event_out) else $error("event longer than one cycle");
a_keep_after_reset: assert property (
    $rose(nrst_in) |-> keep_clock_out && link_clk_sel_out == 2'b10) else $error("reset values");
cover property ($rose(erase_req_out));
cover property (row_wr_out && row_addr_out == 5'h1f);
cover property (sync_event_out);
cover property (sys_rd_out && cpu_clk_off_in);
endmodule // dku_props
bind dku_access dku_props u_props (
    .sys_clk_in, .nrst_in, .lock_bits_in, .cpu_clk_off_in, .bod_fuse_level_in,
    .sync_event_out, .keep_clock_out, .erase_req_out, .bod_force_out, .bod_level_out,
    .nvm_prog_en_out, .row_prog_en_out, .sys_rd_out, .row_wr_out, .row_addr_out,
    .link_clk_sel_out
);
`default_nettype wire

//--- verification/test_dku_access.sv
/* testbench for dku_access: one task per scenario, debugger model on the link.
   assumes: 50 MHz system clock, the model drives all link side inputs except link_reset_in, which the testbench drives. */
`timescale 1ns/10ps
`default_nettype none
`include "dku_access_regs.vh"
module test_dku_access;
logic sys_clk_in, nrst_in, link_clk_in, link_rxd_in, link_reset_in, sync_active_in;
logic cs_wr_in, cs_rd_in, key_valid_in, key_first_in, bus_wr_in, bus_rd_in;
logic [3:0] cs_addr_in;
logic [7:0] cs_wdata_in, key_byte_in, bus_wdata_in, cs_rdata_out, row_data_out, row3, q;
logic [15:0] bus_addr_in, sys_addr_out;
logic [7:0] sys_wdata_out;
logic lock_bits_in, erase_done_in, prog_done_in, cpu_clk_off_in;
logic [1:0] sleep_mode_in, bod_fuse_level_in, bod_level_out;
logic [2:0] crc_status_in;
logic sync_event_out, sys_reset_out, keep_clock_out, erase_req_out, bod_force_out;
logic nvm_prog_en_out, row_prog_en_out, sys_wr_out, sys_rd_out, bus_refused_out, row_wr_out;
logic [4:0] row_addr_out;
int num_errors, compares, n_wr, n_rd, n_ref, n_evt, n_row;
dku_access DUT (.sys_clk_in, .nrst_in, .link_clk_in, .link_rxd_in, .link_reset_in,
    .sync_active_in, .cs_wr_in, .cs_rd_in, .cs_addr_in, .cs_wdata_in, .key_valid_in,
    .key_first_in, .key_byte_in, .bus_wr_in, .bus_rd_in, .bus_addr_in, .bus_wdata_in,
    .lock_bits_in, .erase_done_in, .prog_done_in, .sleep_mode_in, .cpu_clk_off_in,
    .crc_status_in, .bod_fuse_level_in, .cs_rdata_out, .sync_event_out, .sys_reset_out,
    .keep_clock_out, .erase_req_out, .bod_force_out, .bod_level_out, .nvm_prog_en_out,
    .row_prog_en_out, .sys_wr_out, .sys_rd_out, .sys_addr_out, .sys_wdata_out,
    .bus_refused_out, .row_wr_out, .row_addr_out, .row_data_out, .link_ctrl_a_out(),
    .link_ctrl_b_out(), .link_clk_sel_out());
dku_dbg_model m_dbg (.link_clk_out(link_clk_in), .link_rxd_out(link_rxd_in),
    .sync_active_out(sync_active_in), .cs_wr_out(cs_wr_in), .cs_rd_out(cs_rd_in),
    .cs_addr_out(cs_addr_in), .cs_wdata_out(cs_wdata_in), .key_valid_out(key_valid_in),
    .key_first_out(key_first_in), .key_byte_out(key_byte_in), .bus_wr_out(bus_wr_in),
    .bus_rd_out(bus_rd_in), .bus_addr_out(bus_addr_in), .bus_wdata_out(bus_wdata_in),
    .cs_rdata_in(cs_rdata_out));
initial
begin
    sys_clk_in = 1'b0;
    forever #10 sys_clk_in = ~sys_clk_in;
end
always @(posedge sys_clk_in)
begin
    n_wr += sys_wr_out;
    n_rd += sys_rd_out;
    n_ref += bus_refused_out;
    n_evt += sync_event_out;
    n_row += row_wr_out;
    if (row_wr_out && row_addr_out === 5'h03)
        row3 <= row_data_out;
end
task end_of_test;
    begin
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    end
endtask
task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    begin
        compares++;
        if (g !== e)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    end
endtask
task cyc(input int n);
    repeat (n) @(posedge sys_clk_in);
endtask
task wr(input logic [3:0] a, input logic [7:0] d);
    m_dbg.cs_op(1'b1, a, d, q);
endtask
task chk_rd(input logic [3:0] a, input logic [7:0] e);
    begin
        m_dbg.cs_op(1'b0, a, 8'h00, q);
        chk("register", e, q);
    end
endtask
task poll(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    int i;
    begin
        m_dbg.cs_op(1'b0, a, 8'h00, q);
        for (i = 0; i < 20 && (q & m) !== e; i++)
            m_dbg.cs_op(1'b0, a, 8'h00, q);
        chk("polled status", e, q & m);
        if ((q & m) !== e)
            end_of_test;
    end
endtask
task rst_cycle(input logic [7:0] rel);
    begin
        wr(4'h8, `DKU_RESET_SIGNATURE);
        wr(4'h8, rel);
    end
endtask
task t_reset;
    begin
        chk("keep clock", 1, keep_clock_out);
        wr(4'h0, 8'hff);
        chk_rd(4'h0, {`DKU_LINK_REVISION, 4'h0});
        chk_rd(4'h1, 8'h00);
        chk_rd(4'h5, 8'h00);
        chk_rd(4'h7, 8'h00);
        chk_rd(4'h8, 8'h00);
        chk_rd(4'h9, `DKU_CLKSEL_RESET);
        chk_rd(4'ha, 8'h01);
        chk_rd(4'hb, 8'h01);
        chk_rd(4'hc, 8'h05);
        wr(4'h2, 8'hff);
        chk_rd(4'h2, `DKU_LINK_CONTROL_A_MASK);
    end
endtask
task t_keys;
    begin
        m_dbg.send_key(`DKU_ERASE_KEY ^ 64'h1);
        chk_rd(4'h7, 8'h00);
        m_dbg.send_key(`DKU_PROG_KEY);
        chk_rd(4'h7, 8'h10);
        m_dbg.send_key(`DKU_ERASE_KEY);
        chk_rd(4'h7, 8'h18);
    end
endtask
task t_erase;
    begin
        wr(4'h8, `DKU_RESET_SIGNATURE);
        chk("system reset", 1, sys_reset_out);
        chk_rd(4'h8, 8'h01);
        chk_rd(4'h7, 8'h18);
        wr(4'h8, 8'h00);
        cyc(2);
        chk("erase", 1, erase_req_out);
        chk("bod force", 1, bod_force_out);
        chk("bod level", 2'h2, bod_level_out);
        @(posedge sys_clk_in);
        lock_bits_in <= 1'b0;
        erase_done_in <= 1'b1;
        @(posedge sys_clk_in);
        erase_done_in <= 1'b0;
        poll(4'hb, 8'h01, 8'h00);
        chk_rd(4'h7, 8'h10);
    end
endtask
task t_prog;
    begin
        rst_cycle(8'h00);
        poll(4'hb, 8'h08, 8'h08);
        chk("prog enable", 1, nvm_prog_en_out);
        m_dbg.bus_op(1'b1, 16'h1234, 8'h3c);
        cyc(4);
        chk("bus addr", 16'h1234, sys_addr_out);
        chk("bus data", 8'h3c, sys_wdata_out);
        m_dbg.bus_op(1'b0, 16'h1234, 8'h00);
        cyc(4);
        chk("forwarded", 16'h0101, {n_wr[7:0], n_rd[7:0]});
        @(posedge sys_clk_in);
        prog_done_in <= 1'b1;
        @(posedge sys_clk_in);
        prog_done_in <= 1'b0;
        chk_rd(4'h7, 8'h00);
        chk("prog enable", 0, nvm_prog_en_out);
    end
endtask
task t_sleep;
    int s;
    begin
        for (s = 0; s < 4; s++)
        begin
            @(posedge sys_clk_in);
            sleep_mode_in <= s[1:0];
            chk_rd(4'hb, {3'h0, s != 0, 4'h0});
        end
        @(posedge sys_clk_in);
        cpu_clk_off_in <= 1'b1;
        m_dbg.bus_op(1'b0, 16'h0040, 8'h00);
        cyc(4);
        chk("bus reads", 2, n_rd);
        wr(4'ha, 8'h00);
        m_dbg.bus_op(1'b0, 16'h0040, 8'h00);
        cyc(4);
        chk("refused", 1, n_ref);
        m_dbg.sync_char;
        chk("sync events", 5, n_evt);
        wr(4'ha, 8'h01);
        @(posedge sys_clk_in);
        cpu_clk_off_in <= 1'b0;
        sleep_mode_in <= 2'h0;
    end
endtask
task t_row;
    begin
        @(posedge sys_clk_in);
        lock_bits_in <= 1'b1;
        m_dbg.send_key(`DKU_ROW_KEY);
        chk_rd(4'h7, 8'h20);
        rst_cycle(8'h00);
        poll(4'hb, 8'h04, 8'h04);
        chk("row enable", 1, row_prog_en_out);
        m_dbg.bus_op(1'b1, 16'h0003, 8'ha5);
        m_dbg.bus_op(1'b1, 16'h0020, 8'h11);
        m_dbg.bus_op(1'b0, 16'h0003, 8'h00);
        cyc(4);
        chk("refused", 3, n_ref);
        wr(4'ha, 8'h03);
        poll(4'hb, 8'h04, 8'h00);
        chk("row bytes", 32, n_row);
        chk("row byte", 8'ha5, row3);
        wr(4'h7, 8'h20);
        chk_rd(4'h7, 8'h00);
    end
endtask
task t_link;
    begin
        m_dbg.send_key(`DKU_PROG_KEY);
        wr(4'h8, `DKU_RESET_SIGNATURE);
        @(posedge sys_clk_in);
        link_reset_in <= 1'b1;
        cyc(4);
        link_reset_in <= 1'b0;
        cyc(4);
        chk_rd(4'h7, 8'h00);
        chk("system reset", 1, sys_reset_out);
        chk_rd(4'h2, 8'h00);
        wr(4'h8, 8'h5a);
        chk_rd(4'h8, 8'h00);
        wr(4'h3, 8'h04);
        chk_rd(4'h3, 8'h04);
        m_dbg.send_key(`DKU_PROG_KEY);
        chk_rd(4'h7, 8'h00);
    end
endtask
initial
begin
    nrst_in = 1'b0;
    link_reset_in = 1'b0;
    {erase_done_in, prog_done_in, cpu_clk_off_in} = 3'h0;
    lock_bits_in = 1'b1;
    sleep_mode_in = 2'h0;
    bod_fuse_level_in = 2'h2;
    crc_status_in = 3'h5;
    repeat (4) @(posedge sys_clk_in);
    nrst_in <= 1'b1;
    cyc(2);
    t_reset;
    t_keys;
    t_erase;
    t_prog;
    t_sleep;
    t_row;
    t_link;
    end_of_test;
end
initial
begin
    #1000000;
    chk("watchdog", 16'h0, 16'h1);
    end_of_test;
end
endmodule // test_dku_access
`default_nettype wire

//--- verilog/dku_access.v
/*
 * key protected access layer of the single wire debug link: key intake,
 * control and status space registers, system reset request, erase,
 * programming and user row staging control, sync edge event, sleep status.
 * assumes: the link front end drives its request strobes and data as
 * levels that stand across one rising edge of link_clk_in; all other
 * inputs come from system logic on sys_clk_in.
 */
`timescale 1ns/10ps
`default_nettype none
`include "dku_access_regs.vh"

module dku_access (
    input wire sys_clk_in,
    input wire nrst_in,
    input wire link_clk_in,
    input wire link_rxd_in,
    input wire link_reset_in,
    input wire sync_active_in,
    input wire cs_wr_in,
    input wire cs_rd_in,
    input wire [3:0] cs_addr_in,
    input wire [7:0] cs_wdata_in,
    input wire key_valid_in,
    input wire key_first_in,
    input wire [7:0] key_byte_in,
    input wire bus_wr_in,
    input wire bus_rd_in,
    input wire [15:0] bus_addr_in,
    input wire [7:0] bus_wdata_in,
    input wire lock_bits_in,
    input wire erase_done_in,
    input wire prog_done_in,
    input wire [1:0] sleep_mode_in,
    input wire cpu_clk_off_in,
    input wire [2:0] crc_status_in,
    input wire [1:0] bod_fuse_level_in,
    output reg [7:0] cs_rdata_out,
    output reg sync_event_out,
    output wire sys_reset_out,
    output wire keep_clock_out,
    output wire erase_req_out,
    output reg bod_force_out,
    output reg [1:0] bod_level_out,
    output wire nvm_prog_en_out,
    output wire row_prog_en_out,
    output reg sys_wr_out,
    output reg sys_rd_out,
    output reg [15:0] sys_addr_out,
    output reg [7:0] sys_wdata_out,
    output reg bus_refused_out,
    output reg row_wr_out,
    output reg [4:0] row_addr_out,
    output reg [7:0] row_data_out,
    output wire [7:0] link_ctrl_a_out,
    output wire [2:0] link_ctrl_b_out,
    output wire [1:0] link_clk_sel_out
);

    localparam LW = 46;
    localparam ST_IDLE = 2'b01;
    localparam ST_COPY = 2'b10;

    // true when the address falls in the user row staging window
    function row_hit;
        input [15:0] addr;
        begin
            row_hit = (addr[15:5] == `DKU_RAM_BASE_HI);
        end
    endfunction

    // every link signal goes through the same two stages so that data
    // and strobes stay aligned with the sampled link clock
    wire [LW-1:0] lk_raw;
    reg [LW-1:0] lk_meta_q;
    reg [LW-1:0] lk_s_q;
    assign lk_raw = {link_clk_in, link_rxd_in, link_reset_in, sync_active_in,
                     cs_wr_in, cs_rd_in, cs_addr_in, cs_wdata_in, key_valid_in,
                     key_first_in, key_byte_in, bus_wr_in, bus_rd_in, bus_addr_in};

    wire s_lclk = lk_s_q[45];
    wire s_rxd = lk_s_q[44];
    wire s_lrst = lk_s_q[43];
    wire s_sync = lk_s_q[42];
    wire s_cs_wr = lk_s_q[41];
    wire s_cs_rd = lk_s_q[40];
    wire [3:0] s_addr = lk_s_q[39:36];
    wire [7:0] s_wdata = lk_s_q[35:28];
    wire s_kval = lk_s_q[27];
    wire s_kfirst = lk_s_q[26];
    wire [7:0] s_kbyte = lk_s_q[25:18];
    wire s_bwr = lk_s_q[17];
    wire s_brd = lk_s_q[16];
    wire [15:0] s_baddr = lk_s_q[15:0];

    reg [7:0] bus_wd_meta_q;
    reg [7:0] bus_wd_s_q;
    reg lclk_prev_q;
    reg rxd_prev_q;
    reg [63:0] key_sr_q;
    reg [2:0] key_cnt_q;
    reg erase_key_q;
    reg prog_key_q;
    reg row_key_q;
    reg rst_req_q;
    reg erasing_q;
    reg prog_ready_q;
    reg row_ready_q;
    reg [7:0] ctrl_a_q;
    reg [7:0] ctrl_b_q;
    reg [7:0] clk_sel_q;
    reg keep_clk_q;
    reg [1:0] state_q;
    reg [4:0] copy_idx_q;
    reg [7:0] stage_q [0:`DKU_ROW_BYTES-1];
    reg [7:0] rd_val;
    integer i;

    wire lclk_rise = s_lclk & ~lclk_prev_q;
    wire cs_wr_take = lclk_rise & s_cs_wr;
    wire cs_rd_take = lclk_rise & s_cs_rd;
    wire key_take = lclk_rise & s_kval;
    wire bwr_take = lclk_rise & s_bwr;
    wire brd_take = lclk_rise & s_brd;
    wire link_rst = s_lrst | ctrl_b_q[`DKU_LINK_CONTROL_B_DISABLE_BIT];
    wire [63:0] key_word = {s_kbyte, key_sr_q[63:8]};
    wire key_last = key_take & (s_kfirst ? 1'b0 : (key_cnt_q == 3'h7));
    wire rst_write = cs_wr_take & (s_addr == `DKU_REG_RST_REQ);
    wire rst_next = (s_wdata == `DKU_RESET_SIGNATURE);
    wire rst_release = rst_write & rst_req_q & ~rst_next;
    wire sleeping = (sleep_mode_in != 2'b00);
    wire clk_blocked = cpu_clk_off_in & ~keep_clk_q;
    wire bus_open = ~lock_bits_in & ~clk_blocked & ~row_ready_q;
    wire copy_trig = cs_wr_take & (s_addr == `DKU_REG_SYS_CTRL)
                     & s_wdata[`DKU_SYSCTL_COPY_BIT] & row_ready_q;
    wire copy_end = state_q[1] & (copy_idx_q == `DKU_ROW_LAST);

    assign sys_reset_out = rst_req_q;
    assign keep_clock_out = keep_clk_q;
    assign erase_req_out = erasing_q;
    assign nvm_prog_en_out = prog_key_q & ~lock_bits_in & prog_ready_q;
    assign row_prog_en_out = row_key_q & lock_bits_in & row_ready_q;
    assign link_ctrl_a_out = ctrl_a_q;
    assign link_ctrl_b_out = ctrl_b_q[4:2];
    assign link_clk_sel_out = clk_sel_q[1:0];

    always @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            lk_meta_q <= {LW{1'b0}};
            lk_s_q <= {LW{1'b0}};
            bus_wd_meta_q <= 8'h00;
            bus_wd_s_q <= 8'h00;
            lclk_prev_q <= 1'b0;
            rxd_prev_q <= 1'b0;
            sync_event_out <= 1'b0;
        end
        else
        begin
            lk_meta_q <= lk_raw;
            lk_s_q <= lk_meta_q;
            bus_wd_meta_q <= bus_wdata_in;
            bus_wd_s_q <= bus_wd_meta_q;
            lclk_prev_q <= s_lclk;
            rxd_prev_q <= s_rxd;
            // no enable exists for this event on purpose
            sync_event_out <= s_sync & s_rxd & ~rxd_prev_q;
        end
    end

    // key intake and key flags; link reset wins over any key set
    always @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            key_sr_q <= 64'h0000000000000000;
            key_cnt_q <= 3'h0;
            erase_key_q <= 1'b0;
            prog_key_q <= 1'b0;
            row_key_q <= 1'b0;
        end
        else if (link_rst)
        begin
            key_cnt_q <= 3'h0;
            erase_key_q <= 1'b0;
            prog_key_q <= 1'b0;
            row_key_q <= 1'b0;
        end
        else
        begin
            if (key_take)
            begin
                key_sr_q <= key_word;
                key_cnt_q <= s_kfirst ? 3'h1 : key_cnt_q + 3'h1;
            end
            if (erase_done_in)
                erase_key_q <= 1'b0;
            if (prog_done_in)
                prog_key_q <= 1'b0;
            if (cs_wr_take && (s_addr == `DKU_REG_KEY_STAT) && s_wdata[`DKU_KEY_ROW_BIT])
                row_key_q <= 1'b0;
            // sets come last so a clear in the same cycle loses;
            // a mismatch touches no flag and erase leaves prog alone
            if (key_last && key_word == `DKU_ERASE_KEY)
                erase_key_q <= 1'b1;
            if (key_last && key_word == `DKU_PROG_KEY)
                prog_key_q <= 1'b1;
            if (key_last && key_word == `DKU_ROW_KEY)
                row_key_q <= 1'b1;
        end
    end

    // control registers; only the link front end can reach them
    always @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            rst_req_q <= 1'b0;
            ctrl_a_q <= `DKU_LINK_CONTROL_A_RESET;
            ctrl_b_q <= `DKU_LINK_CONTROL_B_RESET;
            clk_sel_q <= `DKU_CLKSEL_RESET;
            keep_clk_q <= `DKU_SYSCTL_RESET;
        end
        else
        begin
            if (rst_write)
                rst_req_q <= rst_next;
            if (cs_wr_take && s_addr == `DKU_REG_CTRL_A)
                ctrl_a_q <= s_wdata & `DKU_LINK_CONTROL_A_MASK;
            else if (link_rst)
                ctrl_a_q <= `DKU_LINK_CONTROL_A_RESET;
            if (cs_wr_take && s_addr == `DKU_REG_CTRL_B)
                ctrl_b_q <= s_wdata & `DKU_LINK_CONTROL_B_MASK;
            if (cs_wr_take && s_addr == `DKU_REG_CLK_SEL)
                clk_sel_q <= s_wdata & `DKU_CLKSEL_MASK;
            if (cs_wr_take && s_addr == `DKU_REG_SYS_CTRL)
                keep_clk_q <= s_wdata[`DKU_SYSCTL_KEEP_BIT];
        end
    end

    // sequences start when the debugger releases the system reset
    always @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            erasing_q <= 1'b0;
            prog_ready_q <= 1'b0;
            row_ready_q <= 1'b0;
            bod_force_out <= 1'b0;
            bod_level_out <= 2'b00;
        end
        else
        begin
            if (erase_done_in)
                erasing_q <= 1'b0;
            if (rst_release && erase_key_q)
                erasing_q <= 1'b1;
            bod_force_out <= erasing_q;
            bod_level_out <= bod_fuse_level_in;
            if (!prog_key_q)
                prog_ready_q <= 1'b0;
            if (rst_release && prog_key_q && !lock_bits_in)
                prog_ready_q <= 1'b1;
            if (!row_key_q || copy_end)
                row_ready_q <= 1'b0;
            if (rst_release && row_key_q && lock_bits_in)
                row_ready_q <= 1'b1;
        end
    end

    // system bus gate and user row staging
    always @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            sys_wr_out <= 1'b0;
            sys_rd_out <= 1'b0;
            sys_addr_out <= 16'h0000;
            sys_wdata_out <= 8'h00;
            bus_refused_out <= 1'b0;
            for (i = 0; i < `DKU_ROW_BYTES; i = i + 1)
                stage_q[i] <= 8'h00;
        end
        else
        begin
            sys_wr_out <= bwr_take & bus_open;
            sys_rd_out <= brd_take & bus_open;
            if ((bwr_take || brd_take) && bus_open)
            begin
                sys_addr_out <= s_baddr;
                sys_wdata_out <= bus_wd_s_q;
            end
            // staged writes count as accepted; reads in row mode never are
            bus_refused_out <= (brd_take & ~bus_open)
                             | (bwr_take & ~bus_open & ~(row_prog_en_out & row_hit(s_baddr)));
            if (bwr_take && row_prog_en_out && row_hit(s_baddr) && state_q[0])
                stage_q[s_baddr[4:0]] <= bus_wd_s_q;
        end
    end

    // copy of the staged page into the user row
    always @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            state_q <= ST_IDLE;
            copy_idx_q <= 5'h00;
            row_wr_out <= 1'b0;
            row_addr_out <= 5'h00;
            row_data_out <= 8'h00;
        end
        else
        begin
            row_wr_out <= 1'b0;
            case (state_q)
                ST_IDLE:
                begin
                    copy_idx_q <= 5'h00;
                    if (copy_trig)
                        state_q <= ST_COPY;
                end
                ST_COPY:
                begin
                    row_wr_out <= 1'b1;
                    row_addr_out <= copy_idx_q;
                    row_data_out <= stage_q[copy_idx_q];
                    copy_idx_q <= copy_idx_q + 5'h01;
                    if (copy_end)
                        state_q <= ST_IDLE;
                end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    // read mux; unmapped offsets read zero
    always @*
    begin
        rd_val = 8'h00;
        if (s_addr == `DKU_REG_REV_STAT)
            rd_val = {`DKU_LINK_REVISION, 4'h0};
        else if (s_addr == `DKU_REG_ERR_STAT)
            rd_val = 8'h00;
        else if (s_addr == `DKU_REG_CTRL_A)
            rd_val = ctrl_a_q;
        else if (s_addr == `DKU_REG_CTRL_B)
            rd_val = ctrl_b_q;
        else if (s_addr == `DKU_REG_KEY_STAT)
            rd_val = {2'b00, row_key_q, prog_key_q, erase_key_q, 3'b000};
        else if (s_addr == `DKU_REG_RST_REQ)
            rd_val = {7'h00, rst_req_q};
        else if (s_addr == `DKU_REG_CLK_SEL)
            rd_val = clk_sel_q;
        else if (s_addr == `DKU_REG_SYS_CTRL)
            rd_val = {7'h00, keep_clk_q};
        else if (s_addr == `DKU_REG_SYS_STAT)
            rd_val = {2'b00, rst_req_q, sleeping, prog_ready_q,
                      row_ready_q, 1'b0, lock_bits_in};
        else if (s_addr == `DKU_REG_CRC_STAT)
            rd_val = {5'h00, crc_status_in};
    end

    // the layer runs on sys_clk_in; keep_clock_out asks to hold it on only while the system control keep bit is set
    always @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            cs_rdata_out <= 8'h00;
        else if (cs_rd_take)
            cs_rdata_out <= rd_val;
    end

endmodule // dku_access

`default_nettype wire

//--- verilog/dku_access_regs.vh
/*
 * register map, field positions, reset values and key signatures of the
 * key protected access layer of the single wire debug link.
 * assumes: included by the access layer module and its testbench.
 */
`ifndef DKU_ACCESS_REGS_VH
`define DKU_ACCESS_REGS_VH

// control and status space offsets
`define DKU_REG_REV_STAT 4'h0
`define DKU_REG_ERR_STAT 4'h1
`define DKU_REG_CTRL_A 4'h2
`define DKU_REG_CTRL_B 4'h3
`define DKU_REG_KEY_STAT 4'h7
`define DKU_REG_RST_REQ 4'h8
`define DKU_REG_CLK_SEL 4'h9
`define DKU_REG_SYS_CTRL 4'ha
`define DKU_REG_SYS_STAT 4'hb
`define DKU_REG_CRC_STAT 4'hc

// revision code is arbitrary
`define DKU_LINK_REVISION 4'h3

// field positions
`define DKU_KEY_ROW_BIT 5
`define DKU_KEY_PROG_BIT 4
`define DKU_KEY_ERASE_BIT 3
`define DKU_LINK_CONTROL_B_DISABLE_BIT 2
`define DKU_SYSCTL_KEEP_BIT 0
`define DKU_SYSCTL_COPY_BIT 1
`define DKU_SST_RSTSYS_BIT 5
`define DKU_SST_SLEEP_BIT 4
`define DKU_SST_PROG_BIT 3
`define DKU_SST_ROW_BIT 2
`define DKU_SST_LOCK_BIT 0

// writable field masks and reset values
`define DKU_LINK_CONTROL_A_MASK 8'hbf
`define DKU_LINK_CONTROL_B_MASK 8'h1c
`define DKU_CLKSEL_MASK 8'h03
`define DKU_LINK_CONTROL_A_RESET 8'h00
`define DKU_LINK_CONTROL_B_RESET 8'h00
`define DKU_CLKSEL_RESET 8'h02
`define DKU_SYSCTL_RESET 1'b1

// reset request signature and key signatures, least significant byte first
`define DKU_RESET_SIGNATURE 8'h59
`define DKU_ERASE_KEY 64'h4e564d4572617365
`define DKU_PROG_KEY 64'h4e564d50726f6720
`define DKU_ROW_KEY 64'h4e564d5573267465

// staging window for the user row, one page
`define DKU_ROW_BYTES 32
`define DKU_ROW_LAST 5'h1f
`define DKU_RAM_BASE_HI 11'h000

`endif
